/* File: core/hes_status_flags.v */
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "hes_defines.vh"

module hes_status_flags (
  // clock and reset
  input  wire        sys_clk,
  input  wire        rstn,
  // host side strobes
  input  wire        host_cmd_wr,
  input  wire [7:0]  host_cmd_byte,
  input  wire        host_data_wr,
  input  wire [1:0]  host_data_idx,
  input  wire [7:0]  host_data_byte,
  output reg  [7:0]  host_status_view,
  output reg         input_buffer_full,
  // firmware bus, write address
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [3:0]  s_axi_awaddr,
  // firmware bus, write data
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  // firmware bus, write response
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  output reg  [1:0]  s_axi_bresp,
  // firmware bus, read address
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  input  wire [3:0]  s_axi_araddr,
  // firmware bus, read data
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  // block interrupt
  output reg         irq
);

  ////////////////////////////////////////////////////////////////////////
  // declarations

  reg  [7:0]              fw_flags_r;
  reg                     cmd_mark_r;
  reg  [`HES_EVT_W-1:0]   evt_stat_r;
  reg  [`HES_EVT_W-1:0]   evt_mask_r;
  reg                     aw_held_r;
  reg                     w_held_r;
  reg  [3:0]              waddr_r;
  reg  [31:0]             wdata_r;
  reg  [3:0]              wstrb_r;
  reg                     aw_held_nxt;
  reg                     w_held_nxt;
  reg                     rvalid_nxt;
  reg  [31:0]             rdata_nxt;
  reg  [1:0]              rresp_nxt;
  reg  [1:0]              bresp_nxt;
  reg  [7:0]              status_byte;
  reg  [`HES_EVT_W-1:0]   evt_set;
  wire                    aw_take;
  wire                    w_take;
  wire                    ar_take;
  wire                    do_wr;
  wire                    wr_status;
  wire                    wr_evt_stat;
  wire                    wr_evt_mask;
  wire                    rd_rx_data;
  wire                    buf_wr_en;
  wire [1:0]              buf_wr_idx;
  wire [7:0]              buf_wr_byte;
  wire [31:0]             rx_word;

  ////////////////////////////////////////////////////////////////////////
  // receive buffer, command lands in byte 0

  assign buf_wr_en   = host_cmd_wr | host_data_wr;
  assign buf_wr_idx  = host_cmd_wr ? 2'h0 : host_data_idx;
  assign buf_wr_byte = host_cmd_wr ? host_cmd_byte : host_data_byte;

  hes_rx_buf #(
    .BYTES (4)
  ) u_rx_buf (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .wr_en     (buf_wr_en),
    .wr_idx    (buf_wr_idx),
    .wr_byte   (buf_wr_byte),
    .rd_word_r (rx_word)
  );

  ////////////////////////////////////////////////////////////////////////
  // bus write path

  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take  = s_axi_wvalid & s_axi_wready;
  assign do_wr   = aw_held_r & w_held_r & ~s_axi_bvalid;

  assign wr_status   = do_wr & (waddr_r == `HES_OFF_STATUS) & wstrb_r[0];
  assign wr_evt_stat = do_wr & (waddr_r == `HES_OFF_EVT_STAT) & wstrb_r[0];
  assign wr_evt_mask = do_wr & (waddr_r == `HES_OFF_EVT_MASK) & wstrb_r[0];

  always @* begin
    aw_held_nxt = aw_held_r;
    w_held_nxt  = w_held_r;
    if (do_wr) begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
    end
    if (aw_take) begin
      aw_held_nxt = 1'b1;
    end
    if (w_take) begin
      w_held_nxt = 1'b1;
    end
    case (waddr_r)
      `HES_OFF_RX_DATA,
      `HES_OFF_STATUS,
      `HES_OFF_EVT_STAT,
      `HES_OFF_EVT_MASK: bresp_nxt = `HES_RESP_OKAY;
      default:           bresp_nxt = `HES_RESP_SLVERR;
    endcase
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      waddr_r       <= 4'h0;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `HES_RESP_OKAY;
    end else begin
      aw_held_r     <= aw_held_nxt;
      w_held_r      <= w_held_nxt;
      // ready drops while a word is parked, so nothing is overwritten
      s_axi_awready <= ~aw_held_nxt;
      s_axi_wready  <= ~w_held_nxt;
      if (aw_take) begin
        waddr_r <= {s_axi_awaddr[3:2], 2'b00};
      end
      if (w_take) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= bresp_nxt;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus read path

  assign ar_take    = s_axi_arvalid & s_axi_arready;
  assign rd_rx_data = ar_take & ({s_axi_araddr[3:2], 2'b00} == `HES_OFF_RX_DATA);

  always @* begin
    rdata_nxt = 32'h0000_0000;
    rresp_nxt = `HES_RESP_OKAY;
    case ({s_axi_araddr[3:2], 2'b00})
      `HES_OFF_RX_DATA:  rdata_nxt = rx_word;
      `HES_OFF_STATUS:   rdata_nxt = {24'h00_0000, status_byte};
      `HES_OFF_EVT_STAT: rdata_nxt = {30'h0000_0000, evt_stat_r};
      `HES_OFF_EVT_MASK: rdata_nxt = {30'h0000_0000, evt_mask_r};
      default:           rresp_nxt = `HES_RESP_SLVERR;
    endcase
    rvalid_nxt = s_axi_rvalid;
    if (s_axi_rvalid && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (ar_take) begin
      rvalid_nxt = 1'b1;
    end
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `HES_RESP_OKAY;
    end else begin
      s_axi_arready <= ~rvalid_nxt;
      s_axi_rvalid  <= rvalid_nxt;
      if (ar_take) begin
        s_axi_rdata <= rdata_nxt;
        s_axi_rresp <= rresp_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status byte storage

  always @* begin
    status_byte = fw_flags_r & `HES_STATUS_FW_MASK;
    status_byte[`HES_BIT_CMD] = cmd_mark_r;
    status_byte[`HES_BIT_IN_FULL] = input_buffer_full;
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      fw_flags_r        <= `HES_STATUS_RESET;
      cmd_mark_r        <= 1'b0;
      input_buffer_full <= 1'b0;
      host_status_view  <= `HES_STATUS_RESET;
    end else begin
      // only firmware writes touch 7,6,5,4,2; no interrupt sits behind 6 and 5
      if (wr_status) begin
        fw_flags_r <= wdata_r[7:0] & `HES_STATUS_FW_MASK;
      end
      // command wins if both strobes land together
      if (host_cmd_wr) begin
        cmd_mark_r <= 1'b1;
      end else if (host_data_wr) begin
        cmd_mark_r <= 1'b0;
      end
      // host set beats firmware drain in the same cycle
      if (host_cmd_wr || (host_data_wr && host_data_idx == 2'h0)) begin
        input_buffer_full <= 1'b1;
      end else if (rd_rx_data) begin
        input_buffer_full <= 1'b0;
      end
      host_status_view <= status_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // block events and interrupt

  always @* begin
    evt_set = {`HES_EVT_W{1'b0}};
    evt_set[`HES_EVT_CMD]  = host_cmd_wr;
    evt_set[`HES_EVT_DATA] = host_data_wr;
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      evt_stat_r <= `HES_EVT_RESET;
      evt_mask_r <= `HES_EVT_RESET;
      irq        <= 1'b0;
    end else begin
      // write-one-to-clear, a fresh event survives its own clear
      if (wr_evt_stat) begin
        evt_stat_r <= (evt_stat_r & ~wdata_r[`HES_EVT_W-1:0]) | evt_set;
      end else begin
        evt_stat_r <= evt_stat_r | evt_set;
      end
      if (wr_evt_mask) begin
        evt_mask_r <= wdata_r[`HES_EVT_W-1:0];
      end
      irq <= |(evt_stat_r & evt_mask_r);
    end
  end

endmodule

`default_nettype wire

/* File: core/hes_defines.vh */
`ifndef HES_DEFINES_VH
`define HES_DEFINES_VH

// register byte addresses on the firmware bus
`define HES_OFF_RX_DATA     4'h0
`define HES_OFF_STATUS      4'h4
`define HES_OFF_EVT_STAT    4'h8
`define HES_OFF_EVT_MASK    4'hc

// status byte field positions
`define HES_BIT_USER_HIGH   7
`define HES_BIT_MGMT_IRQ    6
`define HES_BIT_OS_IRQ      5
`define HES_BIT_BURST       4
`define HES_BIT_CMD         3
`define HES_BIT_USER_LOW    2
`define HES_BIT_IN_FULL     1

// firmware-writable status bits: 7,6,5,4,2
`define HES_STATUS_FW_MASK  8'hf4
`define HES_STATUS_RESET    8'h00

// event status / mask layout
`define HES_EVT_CMD         0
`define HES_EVT_DATA        1
`define HES_EVT_W           2
`define HES_EVT_RESET       2'h0

// bus responses
`define HES_RESP_OKAY       2'h0
`define HES_RESP_SLVERR     2'h2

`endif

/* File: core/hes_rx_buf.v */
`timescale 1ns/1ps
`default_nettype none

module hes_rx_buf #(
  parameter BYTES = 4
) (
  // clock and reset
  input  wire                   sys_clk,
  input  wire                   rstn,
  // byte write port
  input  wire                   wr_en,
  input  wire [1:0]             wr_idx,
  input  wire [7:0]             wr_byte,
  // registered word view
  output reg  [8*BYTES-1:0]     rd_word_r
);

  reg  [7:0] mem_r [0:BYTES-1];
  wire [8*BYTES-1:0] word_nxt;

  genvar g;
  generate
    for (g = 0; g < BYTES; g = g + 1) begin : g_byte
      always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          mem_r[g] <= 8'h00;
        end else if (wr_en && (wr_idx == g)) begin
          mem_r[g] <= wr_byte;
        end
      end
      assign word_nxt[8*g+7:8*g] = mem_r[g];
    end
  endgenerate

  // read data lag the array by one edge
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rd_word_r <= {(8*BYTES){1'b0}};
    end else begin
      rd_word_r <= word_nxt;
    end
  end

endmodule

`default_nettype wire

/* File: tb/hes_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module hes_host_model (
  // clock
  input  wire logic       sys_clk,
  // host strobes
  output var  logic       host_cmd_wr,
  output var  logic [7:0] host_cmd_byte,
  output var  logic       host_data_wr,
  output var  logic [1:0] host_data_idx,
  output var  logic [7:0] host_data_byte
);
  initial {host_cmd_wr, host_data_wr, host_data_idx, host_cmd_byte, host_data_byte} = 0;
  ////////////////////////////////////////
  // idle byte lines show the inverse, so a stale byte never passes
  task automatic put(input logic c, input logic [1:0] i, input logic [7:0] b);
    @(posedge sys_clk);
    host_cmd_wr <= c;
    host_data_wr <= !c;
    host_data_idx <= i;
    {host_cmd_byte, host_data_byte} <= {b, b};
    @(posedge sys_clk);
    {host_cmd_wr, host_data_wr} <= 2'b00;
    {host_cmd_byte, host_data_byte} <= {~b, ~b};
  endtask
endmodule
`default_nettype wire

/* File: tb/hes_status_flags_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module hes_chk (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rstn,
  // host side
  input wire logic       host_cmd_wr,
  input wire logic       host_data_wr,
  input wire logic [1:0] host_data_idx,
  input wire logic [7:0] host_status_view,
  input wire logic       input_buffer_full,
  // firmware bus
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic [1:0] s_axi_rresp
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////
  // view lags storage by one edge, hence two
  property p_cmd; host_cmd_wr |-> ##2 host_status_view[3]; endproperty
  a_cmd: assert property (p_cmd) else $error("cmd bit not set");
  property p_dat; host_data_wr && !host_cmd_wr |-> ##2 !host_status_view[3]; endproperty
  a_dat: assert property (p_dat) else $error("cmd bit not cleared");
  property p_ibc; host_cmd_wr |=> input_buffer_full; endproperty
  a_ibc: assert property (p_ibc) else $error("input full not set by command");
  property p_ibd; host_data_wr && host_data_idx == 2'h0 |=> input_buffer_full; endproperty
  a_ibd: assert property (p_ibd) else $error("input full not set by data");
  property p_hw; !host_status_view[0] && host_status_view[1] == $past(input_buffer_full); endproperty
  a_hw: assert property (p_hw) else $error("hw bits wrong");
  // only a firmware write may move bits 7,6,5,4,2
  property p_fw; !$stable(host_status_view & 8'hf4) |-> $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2); endproperty
  a_fw: assert property (p_fw) else $error("flag moved");
  property p_rst; $rose(rstn) |-> host_status_view == 8'h00 && !input_buffer_full; endproperty
  a_rst: assert property (p_rst) else $error("not clear");
  property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rresp == 2'h0; endproperty
  a_rd: assert property (p_rd) else $error("no read answer");
  c_cmd: cover property (host_cmd_wr);
  c_d0: cover property (host_data_wr && host_data_idx == 2'h0);
  c_rd: cover property (s_axi_rvalid);
endmodule
bind hes_status_flags hes_chk u_chk (.sys_clk, .rstn, .host_cmd_wr, .host_data_wr, .host_data_idx,
  .host_status_view, .input_buffer_full, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rresp);
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk = 0, rstn = 0, host_cmd_wr, host_data_wr, input_buffer_full, irq;
  logic [1:0] host_data_idx, s_axi_bresp, s_axi_rresp;
  logic [7:0] host_cmd_byte, host_data_byte, host_status_view, s, b;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d, q[$];
  int err_count = 0, n_checks = 0, cyc = 0;
  always #5 sys_clk = ~sys_clk;
  hes_status_flags u_dut (.sys_clk, .rstn, .host_cmd_wr, .host_cmd_byte, .host_data_wr, .host_data_idx,
    .host_data_byte, .host_status_view, .input_buffer_full, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .irq);
  hes_host_model u_host (.sys_clk, .host_cmd_wr, .host_cmd_byte, .host_data_wr, .host_data_idx, .host_data_byte);
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    if (err_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      end_sim();
    end
  end
  // read data against the oldest note, both responses as they are taken
  always @(posedge sys_clk) begin
    if (rstn && s_axi_rvalid && s_axi_rready) begin
      chk(s_axi_rdata, q.pop_front());
      chk(s_axi_rresp, 2'h0);
    end
    if (rstn && s_axi_bvalid && s_axi_bready)
      chk(s_axi_bresp, 2'h0);
  end
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [3:0] m = 4'h1);
    logic aw = 0, w = 0;
    @(posedge sys_clk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, v, m};
    {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
    while (!(aw && w)) begin
      @(posedge sys_clk);
      if (!aw && s_axi_awready) begin
        aw = 1;
        s_axi_awvalid <= 0;
      end
      if (!w && s_axi_wready) begin
        w = 1;
        s_axi_wvalid <= 0;
      end
    end
    s_axi_bready <= 1;
    do @(posedge sys_clk); while (!s_axi_bvalid);
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    q.push_back(e);
    @(posedge sys_clk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    do @(posedge sys_clk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge sys_clk); while (!s_axi_rvalid);
    s_axi_rready <= 0;
  endtask
  ////////////////////////////////////////
  initial begin
    void'($urandom(98));
    repeat (5) @(posedge sys_clk);
    rstn <= 1;
    rd(4'h4, 0);
    rd(4'hc, 0);
    // mask fully open, so a leak of bits 6 and 5 into irq would show
    wr(4'hc, 3);
    for (int i = 0; i < 3; i++) begin
      d = $urandom;
      if (i == 0) d[7:0] = 8'hff;
      wr(4'h4, d);
      s = d[7:0] & 8'hf4;
      rd(4'h4, {24'h0, s});
      wt(1);
      chk(host_status_view, s);
      chk(irq, 0);
    end
    // lane 0 off: the flags must not move
    wr(4'h4, ~d, 4'h0);
    rd(4'h4, {24'h0, s});
    b = $urandom;
    u_host.put(1, 0, b);
    wt(1);
    chk(host_status_view, s | 8'h0a);
    rd(4'h0, {24'h0, b});
    for (int i = 3; i >= 0; i--) begin
      d[8*i +: 8] = $urandom;
      u_host.put(0, i[1:0], d[8*i +: 8]);
      wt(1);
      chk(host_status_view[3], 0);
      chk(input_buffer_full, i == 0);
    end
    rd(4'h4, {24'h0, s | 8'h02});
    rd(4'h0, d);
    wr(4'h8, 3);
    wr(4'hc, 1);
    u_host.put(0, 1, $urandom);
    wt(2);
    chk(irq, 0);
    u_host.put(1, 0, $urandom);
    wt(2);
    chk(irq, 1);
    wr(4'h8, 1);
    wt(2);
    chk(irq, 0);
    rd(4'h8, 2);
    @(posedge sys_clk);
    rstn <= 0;
    wt(2);
    @(posedge sys_clk);
    rstn <= 1;
    wt(1);
    chk(host_status_view, 0);
    rd(4'h0, 0);
    rd(4'h4, 0);
    rd(4'hc, 0);
    repeat (2) @(posedge sys_clk);
    chk(q.size(), 0);
    end_sim();
  end
endmodule
`default_nettype wire
